// ---- rtl/fma_pkg.sv ----
// fused multiply-add special-case unit: constants, carriers
// assumes a single core clock domain and an apb register master
package fma_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFF_CSR = 8'h00;
	localparam logic [7:0] OFF_FEAT = 8'h04;
	localparam logic [7:0] OFF_IST = 8'h08;
	localparam logic [7:0] OFF_IMSK = 8'h0C;
	// float_control_status_reg layout and reset
	localparam logic [31:0] CSR_RESET = 32'h00001F80;
	localparam int FLG_INV = 0;
	localparam int FLG_DE = 1;
	localparam int FLG_OE = 3;
	localparam int FLG_UE = 4;
	localparam int FLG_PE = 5;
	localparam int MSK_LSB = 7;
	localparam int RC_LSB = 13;
	localparam logic [31:0] CSR_WMASK = 32'h00007FBF;
	// feature word, unit present flag at bit 12
	localparam logic [31:0] FEAT_WORD = 32'h00001000;
	// immediate_control_byte fields
	localparam int IMM_RC_SEL = 2;
	localparam int IMM_SUPP = 3;
	// interrupt events
	localparam int EV_DONE = 0;
	localparam int EV_FAULT = 1;
	// lanes and number formats
	localparam int LANES = 8;
	localparam int NARROW_LANES = 4;
	localparam int QNAN_BIT = 22;
	localparam logic [31:0] QNAN_INDEF = 32'hFFC00000;
	localparam logic [30:0] MAG_INF = 31'h7F800000;
	localparam logic [30:0] MAG_MAX = 31'h7F7FFFFF;
	localparam logic [10:0] EXP_BIAS = 11'h07F;
	localparam logic [10:0] SCALE_OFS = 11'h04A;

	typedef enum logic [1:0] {
		RM_NEAR = 2'h0,
		RM_DOWN = 2'h1,
		RM_UP = 2'h2,
		RM_ZERO = 2'h3
	} fma_rm_t;

	// one issued vector operation; op[0] negates addend, op[1] product
	typedef struct packed {
		logic [1:0] op;
		logic [7:0] imm;
		logic wide;
		logic [255:0] x;
		logic [255:0] y;
		logic [255:0] z;
	} fma_issue_t;

	typedef struct packed {
		logic [31:0] res;
		logic [5:0] flags;
	} fma_lane_t;
endpackage

// ---- rtl/fma_unit.sv ----
// fused multiply-add unit: special cases, rounding, exceptions, apb regs
// assumes operands issued by the pipeline on core_clk, apb master on core_clk
`timescale 1ns/100ps
module fma_unit (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic issue_valid,
	input wire fma_pkg::fma_issue_t issue,
	output logic result_valid,
	output logic [255:0] result_data,
	output logic fp_fault,
	output logic irq
);

	////////////////////////////////////////////////////////////////////
	// one lane, single precision: returns result and raised flags
	function automatic fma_pkg::fma_lane_t fma_lane(
		input logic [31:0] x,
		input logic [31:0] y,
		input logic [31:0] z,
		input logic [1:0] op,
		input logic [1:0] rm
	);
		fma_pkg::fma_lane_t r;
		logic xn, yn, zn, xi, yi, zi, x0, y0, z0, sp, sz, rd, sa, sb, sr, st, g, rest, inc;
		logic [23:0] mx, my, mz;
		logic [47:0] pm;
		logic [10:0] ex, ey, ez, ep, eb, d, er;
		logic [76:0] a, b, s, n, lo;
		logic [6:0] p;
		logic [24:0] mr;
		r = '0;
		xn = (&x[30:23]) && (|x[22:0]);
		yn = (&y[30:23]) && (|y[22:0]);
		zn = (&z[30:23]) && (|z[22:0]);
		xi = x[30:0] == fma_pkg::MAG_INF;
		yi = y[30:0] == fma_pkg::MAG_INF;
		zi = z[30:0] == fma_pkg::MAG_INF;
		x0 = x[30:0] == 31'h00000000;
		y0 = y[30:0] == 31'h00000000;
		z0 = z[30:0] == 31'h00000000;
		sp = x[31] ^ y[31] ^ op[1];
		sz = z[31] ^ op[0];
		rd = rm == fma_pkg::RM_DOWN;
		// denormal operand flag when no nan is involved
		r.flags[fma_pkg::FLG_DE] = !(xn | yn | zn) &&
			((x[30:23] == 8'h00 && !x0) || (y[30:23] == 8'h00 && !y0) ||
			(z[30:23] == 8'h00 && !z0));
		mx = {|x[30:23], x[22:0]};
		my = {|y[30:23], y[22:0]};
		mz = {|z[30:23], z[22:0]};
		ex = {3'h0, x[30:23] | {7'h00, ~|x[30:23]}};
		ey = {3'h0, y[30:23] | {7'h00, ~|y[30:23]}};
		ez = {3'h0, z[30:23] | {7'h00, ~|z[30:23]}};
		pm = mx * my;
		ep = ex + ey - fma_pkg::EXP_BIAS;
		a = {1'b0, pm, 28'h0000000};
		b = {2'h0, mz, 51'h0};
		st = 1'b0;
		s = '0;
		n = '0;
		p = '0;
		mr = '0;
		g = 1'b0;
		rest = 1'b0;
		inc = 1'b0;
		er = '0;
		sr = sp;
		if (xn | yn | zn) begin
			// first nan in x, y, z order, quietized
			r.flags[fma_pkg::FLG_INV] = (xn & !x[22]) | (yn & !y[22]) | (zn & !z[22]);
			r.res = xn ? x : (yn ? y : z);
			r.res[fma_pkg::QNAN_BIT] = 1'b1;
		end else if ((xi & y0) | (x0 & yi) | ((xi | yi) & zi & (sp != sz))) begin
			r.flags[fma_pkg::FLG_INV] = 1'b1;
			r.res = fma_pkg::QNAN_INDEF;
		end else if (xi | yi) begin
			r.res = {sp, fma_pkg::MAG_INF};
		end else if (zi) begin
			r.res = {sz, fma_pkg::MAG_INF};
		end else if ((x0 | y0) & z0) begin
			r.res = {(sp == sz) ? sp : rd, 31'h00000000};
		end else if (x0 | y0) begin
			r.res = {sz, z[30:0]};
		end else begin
			// align smaller term to larger, keep sticky bit
			if (z0 || $signed(ep) >= $signed(ez)) begin
				eb = ep;
				sa = sp;
				sb = sz;
				d = z0 ? 11'h07F : ep - ez;
			end else begin
				eb = ez;
				sa = sz;
				sb = sp;
				d = ez - ep;
				n = a;
				a = b;
				b = n;
			end
			if (d > 11'h04C) begin
				st = |b;
				b = '0;
			end else begin
				lo = (77'h1 << d[6:0]) - 77'h1;
				st = |(b & lo);
				b = b >> d[6:0];
			end
			// single exact sum, rounded once below
			if (sa == sb) begin
				s = a + b;
				sr = sa;
			end else if (a >= b) begin
				s = a - b - {76'h0, st};
				sr = sa;
			end else begin
				s = b - a;
				sr = sb;
			end
			if (s == 77'h0 && !st) begin
				r.res = {rd, 31'h00000000};
			end else begin
				for (int i = 0; i < 77; i++) begin
					if (s[i]) begin
						p = 7'(i);
					end
				end
				n = s << (7'h4C - p);
				mr = {1'b0, n[76:53]};
				g = n[52];
				rest = (|n[51:0]) | st;
				unique case (fma_pkg::fma_rm_t'(rm))
					fma_pkg::RM_NEAR: inc = g & (rest | mr[0]);
					fma_pkg::RM_UP: inc = !sr & (g | rest);
					fma_pkg::RM_DOWN: inc = sr & (g | rest);
					fma_pkg::RM_ZERO: inc = 1'b0;
				endcase
				mr = mr + {24'h0, inc};
				er = {4'h0, p} + eb - fma_pkg::SCALE_OFS + {10'h0, mr[24]};
				r.flags[fma_pkg::FLG_PE] = g | rest;
				if ($signed(er) >= $signed(11'h0FF)) begin
					r.flags[fma_pkg::FLG_OE] = 1'b1;
					r.flags[fma_pkg::FLG_PE] = 1'b1;
					r.res = (rm == fma_pkg::RM_NEAR || (rm == fma_pkg::RM_UP && !sr) ||
						(rd && sr)) ? {sr, fma_pkg::MAG_INF} : {sr, fma_pkg::MAG_MAX};
				end else if ($signed(er) <= $signed(11'h000)) begin
					// tiny results flush to signed zero
					r.flags[fma_pkg::FLG_UE] = 1'b1;
					r.flags[fma_pkg::FLG_PE] = 1'b1;
					r.res = {sr, 31'h00000000};
				end else begin
					r.res = {sr, er[7:0], mr[24] ? 23'h000000 : mr[22:0]};
				end
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// registers
	logic [31:0] csr_ff, nxt_csr;
	logic [1:0] ist_ff, nxt_ist;
	logic [1:0] imsk_ff, nxt_imsk;
	logic [255:0] dest_ff, nxt_dest;
	logic valid_ff, fault_ff;

	// apb decode
	wire logic wr_acc = psel && penable && pwrite;
	wire logic hit_csr = paddr == fma_pkg::OFF_CSR;
	wire logic hit_feat = paddr == fma_pkg::OFF_FEAT;
	wire logic hit_ist = paddr == fma_pkg::OFF_IST;
	wire logic hit_imsk = paddr == fma_pkg::OFF_IMSK;
	wire logic hit_any = hit_csr | hit_feat | hit_ist | hit_imsk;

	// rounding mode source
	wire logic [1:0] eff_rm = issue.imm[fma_pkg::IMM_RC_SEL] ? issue.imm[1:0] :
		csr_ff[fma_pkg::RC_LSB +: 2];
	wire logic supp = issue.imm[fma_pkg::IMM_SUPP];

	////////////////////////////////////////////////////////////////////
	// lane array, upper half idle for the 128-bit form
	fma_pkg::fma_lane_t lane_r [fma_pkg::LANES];
	logic [255:0] lane_res;
	logic [5:0] lane_flg [fma_pkg::LANES];
	genvar gi;
	generate
		for (gi = 0; gi < fma_pkg::LANES; gi++) begin : g_lane
			assign lane_r[gi] = fma_lane(issue.x[gi*32 +: 32], issue.y[gi*32 +: 32],
				issue.z[gi*32 +: 32], issue.op, eff_rm);
			wire logic act = issue.wide || gi < fma_pkg::NARROW_LANES;
			assign lane_res[gi*32 +: 32] = act ? lane_r[gi].res : 32'h00000000;
			assign lane_flg[gi] = act ? lane_r[gi].flags : 6'h00;
		end
	endgenerate

	// flag merge and exception gating
	logic [5:0] all_flg;
	always_comb begin
		all_flg = 6'h00;
		for (int i = 0; i < fma_pkg::LANES; i++) begin
			all_flg = all_flg | lane_flg[i];
		end
	end
	wire logic [5:0] raised = (issue_valid && !supp) ? all_flg : 6'h00;
	wire logic [5:0] unmasked = raised & ~csr_ff[fma_pkg::MSK_LSB +: 6];
	wire logic fault = |unmasked;
	wire logic done = issue_valid && !fault;

	////////////////////////////////////////////////////////////////////
	// next-state values; hardware set wins over software clear
	assign nxt_csr = ((wr_acc && hit_csr) ? (pwdata & fma_pkg::CSR_WMASK) : csr_ff) |
		{26'h0, raised};
	assign nxt_ist = (ist_ff & ~((wr_acc && hit_ist) ? pwdata[1:0] : 2'h0)) |
		{fault, done};
	assign nxt_imsk = (wr_acc && hit_imsk) ? pwdata[1:0] : imsk_ff;
	assign nxt_dest = done ? lane_res : dest_ff;

	// state update
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			csr_ff <= fma_pkg::CSR_RESET;
			ist_ff <= 2'h0;
			imsk_ff <= 2'h0;
			dest_ff <= '0;
			valid_ff <= 1'b0;
			fault_ff <= 1'b0;
		end else begin
			csr_ff <= nxt_csr;
			ist_ff <= nxt_ist;
			imsk_ff <= nxt_imsk;
			dest_ff <= nxt_dest;
			valid_ff <= done;
			fault_ff <= issue_valid && fault;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;
	assign prdata = hit_csr ? csr_ff :
		hit_feat ? fma_pkg::FEAT_WORD :
		hit_ist ? {30'h0, ist_ff} :
		hit_imsk ? {30'h0, imsk_ff} : 32'h00000000;
	assign result_valid = valid_ff;
	assign result_data = dest_ff;
	assign fp_fault = fault_ff;
	assign irq = |(ist_ff & imsk_ff);

	////////////////////////////////////////////////////////////////////
	// checks; helpers look at lane 0 only
	wire logic l0_x0 = issue.x[30:0] == 31'h00000000;
	wire logic l0_z0 = issue.z[30:0] == 31'h00000000;
	wire logic l0_yf = issue.y[30:23] != 8'hFF;
	wire logic l0_sp = issue.x[31] ^ issue.y[31] ^ issue.op[1];
	wire logic l0_sz = issue.z[31] ^ issue.op[0];
	wire logic l0_zsgn = (l0_sp == l0_sz) ? l0_sp : (eff_rm == fma_pkg::RM_DOWN);
	wire logic l0_xnan = (&issue.x[30:23]) && (|issue.x[22:0]);
	wire logic l0_zinf = issue.z[30:0] == fma_pkg::MAG_INF;
	wire logic l0_xyfin = !(&issue.x[30:23]) && l0_yf;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_accept;
		issue_valid && !fault;
	endsequence

	chk_zero_sign: assert property (
		s_accept and (l0_x0 && l0_z0 && l0_yf) |=>
		result_data[31:0] == {$past(l0_zsgn), 31'h00000000})
		else $error("zero plus zero gave wrong signed zero");
	chk_inf_addend: assert property (
		s_accept and (l0_zinf && l0_xyfin && !(&issue.y[30:23] && |issue.y[22:0])) |=>
		result_data[31:0] == {$past(l0_sz), fma_pkg::MAG_INF})
		else $error("infinite addend did not give signed infinity");
	chk_nan_quiet: assert property (
		s_accept and l0_xnan |=>
		result_data[31:0] == ($past(issue.x[31:0]) | 32'h00400000))
		else $error("nan operand not passed quietized");
	chk_fault_dest: assert property (
		issue_valid && fault |=> fp_fault && !result_valid && $stable(result_data))
		else $error("faulting issue changed destination");
	chk_suppress_flags: assert property (
		issue_valid && supp && !(wr_acc && hit_csr) |=> $stable(csr_ff[5:0]) && !fp_fault)
		else $error("suppressed issue touched flags or faulted");
	chk_invalid_flag: assert property (
		issue_valid && !supp && all_flg[fma_pkg::FLG_INV] |=> csr_ff[fma_pkg::FLG_INV])
		else $error("invalid operation did not set invalid flag");
	chk_feature_read: assert property (
		psel && penable && !pwrite && hit_feat |-> prdata[12] && pready)
		else $error("feature word lacks unit present bit");
	chk_narrow_zero: assert property (
		s_accept and !issue.wide |=> result_valid ##0 result_data[255:128] == '0)
		else $error("narrow form left upper lanes nonzero");
	chk_done_event: assert property (
		s_accept |=> ist_ff[fma_pkg::EV_DONE] && result_valid)
		else $error("completion did not set its status bit");

	// more lane 0 and status helpers
	wire logic l0_y0 = issue.y[30:0] == 31'h00000000;
	wire logic l0_zfin = issue.z[30:23] != 8'hFF;
	wire logic wr_ist = wr_acc && hit_ist;

	// a faulting issue, then its pulse and status bit
	sequence s_fault;
		issue_valid && fault;
	endsequence

	sequence s_fault_seen;
		fp_fault && ist_ff[fma_pkg::EV_FAULT];
	endsequence

	chk_addend_pass: assert property (
		s_accept and (l0_x0 && l0_yf && !l0_z0 && l0_zfin) |=>
		result_data[31:0] == {$past(l0_sz), $past(issue.z[30:0])})
		else $error("zero product did not pass the addend");
	chk_product_sign: assert property (
		s_accept and (l0_xyfin && !l0_x0 && !l0_y0 && l0_z0) |=>
		result_data[31] == $past(l0_sp))
		else $error("product with zero addend has wrong sign");
	chk_fault_event: assert property (
		s_fault |=> s_fault_seen)
		else $error("fault did not pulse or set its status bit");
	chk_unmapped_err: assert property (
		psel && penable && !hit_any |-> pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");
	chk_status_clear: assert property (
		wr_ist && pwdata[fma_pkg::EV_DONE] && !done |=> !ist_ff[fma_pkg::EV_DONE])
		else $error("done status bit not cleared by writing one");
	chk_set_wins: assert property (
		wr_ist && pwdata[fma_pkg::EV_DONE] && done |=> ist_ff[fma_pkg::EV_DONE])
		else $error("clear beat a same-cycle completion");

endmodule

// ---- testbench/fma_pipe_model.sv ----
// pipeline model: issues one operation at a time to the unit
// assumes core_clk shared with the unit and the bench
`timescale 1ns/100ps
module fma_pipe_model (
	input wire logic core_clk,
	output logic issue_valid,
	output fma_pkg::fma_issue_t issue
);
	initial begin
		issue_valid = 1'b0;
		issue = '0;
	end
	// one-cycle pulse, same operands in every lane
	task automatic send(input logic [1:0] op, input logic [7:0] imm, input logic wide,
		input logic [31:0] x, input logic [31:0] y, input logic [31:0] z);
		@(posedge core_clk);
		issue_valid <= 1'b1;
		issue <= '{op: op, imm: imm, wide: wide, x: {8{x}}, y: {8{y}}, z: {8{z}}};
		@(posedge core_clk);
		issue_valid <= 1'b0;
		// released operands do not keep their last value
		issue <= ~issue;
	endtask
endmodule

// ---- testbench/fused_multiply_add_special_cases_tb.sv ----
// bench for the fma unit: apb register tasks plus issued operations
// assumes fma_pipe_model drives the issue port on the same clock
`timescale 1ns/100ps
module fused_multiply_add_special_cases_tb;
	localparam logic [31:0] ONE = 32'h3F800000;
	localparam logic [31:0] TWO = 32'h40000000;
	localparam logic [31:0] THR = 32'h40400000;
	localparam logic [31:0] PINF = 32'h7F800000;
	localparam logic [31:0] NINF = 32'hFF800000;
	localparam logic [31:0] NZ = 32'h80000000;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, q, prev;
	logic pready, pslverr, serr, issue_valid, result_valid, fp_fault, irq;
	logic [255:0] result_data;
	fma_pkg::fma_issue_t issue;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	fma_unit i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .issue_valid(issue_valid), .issue(issue),
		.result_valid(result_valid), .result_data(result_data), .fp_fault(fp_fault), .irq(irq));
	fma_pipe_model i_pipe (.core_clk(core_clk), .issue_valid(issue_valid), .issue(issue));
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	// hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer, waits for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic run(input logic [1:0] op, input logic [7:0] imm, input logic wide,
		input logic [31:0] x, input logic [31:0] y, input logic [31:0] z);
		i_pipe.send(op, imm, wide, x, y, z);
		#1;
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, fma_pkg::OFF_CSR, 32'h0);
		chk(q, fma_pkg::CSR_RESET);
		apb(1'b0, fma_pkg::OFF_FEAT, 32'h0);
		chk(q & 32'h00001000, 32'h00001000);
		apb(1'b0, 8'h10, 32'h0);
		chk({serr, q}, {1'b1, 32'h0});
		$display("test regs done");
		for (int i = 0; i < 4; i++) begin
			run(i[1:0], 8'h00, 1'b1, ONE, TWO, PINF);
			chk(result_data[31:0], i[0] ? NINF : PINF);
		end
		run(2'h0, 8'h00, 1'b1, 32'h0, TWO, THR);
		chk(result_data[31:0], THR);
		run(2'h1, 8'h00, 1'b1, 32'h0, TWO, THR);
		chk(result_data[31:0], 32'hC0400000);
		run(2'h0, 8'h00, 1'b1, TWO, THR, 32'h0);
		chk(result_data[31:0], 32'h40C00000);
		run(2'h2, 8'h00, 1'b1, TWO, THR, NZ);
		chk(result_data[31:0], 32'hC0C00000);
		$display("test finite done");
		run(2'h1, 8'h00, 1'b1, ONE, TWO, TWO);
		chk(result_data[31:0], 32'h0);
		run(2'h1, 8'h05, 1'b1, ONE, TWO, TWO);
		chk(result_data[31:0], NZ);
		run(2'h1, 8'h01, 1'b1, ONE, TWO, TWO);
		chk(result_data[31:0], 32'h0);
		run(2'h0, 8'h00, 1'b1, 32'h0, 32'hBF800000, NZ);
		chk(result_data[31:0], NZ);
		run(2'h0, 8'h00, 1'b1, 32'h0, ONE, NZ);
		chk(result_data[31:0], 32'h0);
		run(2'h0, 8'h05, 1'b1, 32'h0, ONE, NZ);
		chk(result_data[31:0], NZ);
		$display("test zeros done");
		run(2'h0, 8'h00, 1'b1, 32'h7F800001, ONE, ONE);
		chk(result_data[31:0], 32'h7FC00001);
		apb(1'b0, fma_pkg::OFF_CSR, 32'h0);
		chk(q, fma_pkg::CSR_RESET | 32'h1);
		run(2'h0, 8'h00, 1'b0, ONE, TWO, ONE);
		chk({result_data[127:96], result_data[255:224]}, {THR, 32'h0});
		run(2'h0, 8'h00, 1'b1, ONE, TWO, ONE);
		chk(result_data[255:224], THR);
		$display("test lanes done");
		apb(1'b1, fma_pkg::OFF_IST, 32'h3);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, fma_pkg::OFF_IMSK, 32'h1);
		run(2'h0, 8'h00, 1'b1, ONE, ONE, ONE);
		chk({30'h0, result_valid, irq}, 32'h3);
		apb(1'b0, fma_pkg::OFF_IST, 32'h0);
		chk(q, 32'h1);
		apb(1'b1, fma_pkg::OFF_IST, 32'h1);
		chk({31'h0, irq}, 32'h0);
		// completion in the same cycle as a clear of its bit
		fork
			apb(1'b1, fma_pkg::OFF_IST, 32'h1);
			begin
				@(posedge core_clk);
				run(2'h0, 8'h00, 1'b1, ONE, ONE, ONE);
			end
		join
		apb(1'b0, fma_pkg::OFF_IST, 32'h0);
		chk({irq, q}, {1'b1, 32'h1});
		$display("test irq done");
		apb(1'b1, fma_pkg::OFF_CSR, 32'h00001F00);
		apb(1'b1, fma_pkg::OFF_IMSK, 32'h2);
		prev = result_data[31:0];
		run(2'h0, 8'h00, 1'b1, PINF, 32'h0, ONE);
		chk({29'h0, fp_fault, result_valid, irq}, 32'h5);
		chk(result_data[31:0], prev);
		apb(1'b0, fma_pkg::OFF_CSR, 32'h0);
		chk(q, 32'h00001F01);
		apb(1'b1, fma_pkg::OFF_CSR, 32'h00001F00);
		run(2'h0, 8'h08, 1'b1, PINF, 32'h0, ONE);
		chk({30'h0, fp_fault, result_valid}, 32'h1);
		chk(result_data[31:0], fma_pkg::QNAN_INDEF);
		apb(1'b0, fma_pkg::OFF_CSR, 32'h0);
		chk(q, 32'h00001F00);
		$display("test fault done");
		apb(1'b1, fma_pkg::OFF_CSR, 32'h00005F80);
		run(2'h0, 8'h00, 1'b1, ONE, ONE, 32'h30800000);
		chk(result_data[31:0], 32'h3F800001);
		run(2'h0, 8'h07, 1'b1, ONE, ONE, 32'h30800000);
		chk(result_data[31:0], ONE);
		run(2'h0, 8'h04, 1'b1, 32'h7F7FFFFF, TWO, 32'h0);
		chk(result_data[31:0], PINF);
		run(2'h0, 8'h07, 1'b1, 32'h7F7FFFFF, TWO, 32'h0);
		chk(result_data[31:0], 32'h7F7FFFFF);
		run(2'h0, 8'h00, 1'b1, 32'h00800000, 32'h3F000000, 32'h0);
		chk(result_data[31:0], 32'h0);
		apb(1'b0, fma_pkg::OFF_CSR, 32'h0);
		chk(q, 32'h00005FB8);
		apb(1'b1, fma_pkg::OFF_CSR, 32'h00001B80);
		prev = result_data[31:0];
		run(2'h0, 8'h00, 1'b1, 32'h7F7FFFFF, TWO, 32'h0);
		chk({fp_fault, result_valid, result_data[31:0]}, {2'h2, prev});
		$display("test rounding done");
		give_verdict();
	end
endmodule
